// ### logic/irq_pkg.sv
// Shared constants and carrier types for the pending-flag and host pin block
package irq_pkg;

    // ==========================================================
    // Geometry
    localparam int NUM_SOURCES = 32;
    localparam int NUM_HOST_PINS = 4;
    localparam int SETTING_FIELD_W = 4;
    localparam int MODE_BIT = 3;          // Top bit of each setting field: 1 = level
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] OFF_PENDING_FLAGS = 8'h00;
    localparam logic [7:0] OFF_PENDING_CLEAR = 8'h04;
    localparam logic [7:0] OFF_SOURCE_MASK = 8'h08;
    localparam logic [7:0] OFF_SETTING0 = 8'h0c;
    localparam logic [7:0] OFF_SETTING1 = 8'h10;
    localparam logic [7:0] OFF_SETTING2 = 8'h14;
    localparam logic [7:0] OFF_SETTING3 = 8'h18;
    localparam logic [7:0] OFF_HOST_IRQ_CONTROL = 8'h1c;

    // ==========================================================
    // Host control field positions
    localparam int HOST_VALUE_LSB = 0;
    localparam int HOST_ENABLE_LSB = 4;
    localparam int HOST_SENSE_LSB = 8;

    // ==========================================================
    // Source numbers
    localparam int SRC_PCI_FIRST = 0;
    localparam int SRC_USER = 4;
    localparam int SRC_HOST_COMM = 28;
    localparam logic [31:0] RESERVED_SOURCES = 32'h0df8_0000; // 19..24, 26..27
    localparam logic [31:0] SOFTWARE_SOURCES = 32'hf000_0000; // 28..31
    localparam logic [31:0] PIN_SOURCES = 32'h0000_001f;      // 0..4

    // ==========================================================
    // Values after reset
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [127:0] RESET_SETTING = 128'h0;
    localparam logic [3:0] RESET_HOST = 4'h0;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic [3:0] driveLow;   // Output value, always low when driven
        logic [3:0] oeN;        // Low while the pin is pulled low
    } host_pins_t;

endpackage : irq_pkg

// ### logic/sync_bank.sv
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps

module sync_bank #(
    parameter int WIDTH = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);

    // ==========================================================
    // Stage registers
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second stage, nothing else looks at it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= '0;
            synced <= '0;
        end else begin
            stage1 <= async;
            synced <= stage1;
        end
    end

endmodule : sync_bank

// ### logic/irq_pending_and_host_pins.sv
// Pending-flag registers, source modes and host interrupt pins behind Wishbone
`timescale 1ns/1ps

// What this block does
// RULE1 - Level-mode bits read back the live request line, not a latch.
// RULE2 - Edge-mode bit reads 1 only while captured and not yet dispatched.
// RULE3 - Writing pending flags sets each edge-mode source written with 1.
// RULE4 - Pending and clear writes leave level-mode sources untouched.
// RULE5 - Software-raised requests only wait pending; no immediate trap.
// RULE6 - Software may raise any of the 32 sources; prefer free ones.
// RULE7 - Another bus master may raise sources through the same register.
// RULE8 - Clear register reads back exactly the pending flags.
// RULE9 - Writing the clear register drops each edge-mode flag written with 1.
// RULE10 - A hardware set in the same cycle as a clear wins.
// RULE11 - Handler software should save and zero the mask before jumping.
// RULE12 - Pins feed sources 0..3 and source 4, all in either mode.
// RULE13 - Bus interrupt inputs are active low; falling edge in edge mode.
// RULE14 - User request pin is active high.
// RULE15 - Sources 19..24, 26..27 unconnected; 28..31 software edge sources.
// RULE16 - Each host pin has its own drive-enable bit.
// RULE17 - Enabled pin with assert value 1 is pulled low, else undriven.
// RULE18 - Sense bits read 1 while the host pin is electrically low.
// RULE19 - Unused host pins serve as software-controlled I/O.
// RULE20 - Hardware never changes host pins on its own.
// RULE21 - Top bit of each setting field selects edge (0) or level (1).
// RULE22 - In edge mode a leading edge sets the flag until dispatch or clear.
// RULE23 - Dispatch of an edge-mode vector drops its pending flag.
// RULE24 - Reset zeroes pending flags, clear state and source mask.
// RULE25 - Pins are synchronised to the clock before edge or level use.
// RULE26 - Host control bits reset to zero, all drivers disabled.
module irq_pending_and_host_pins
    import irq_pkg::*;
#(
    parameter int NSRC = NUM_SOURCES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Wishbone slave
    input wire wb_req_t wbReq,
    output wb_rsp_t wbRsp,
    // On-chip request lines, same clock, active high
    input wire logic [NSRC-1:0] deviceRequest,
    // Vector dispatch from the arbiter
    input wire logic dispatchValid,
    input wire logic [4:0] dispatchSource,
    // Toward the arbiter
    output logic [NSRC-1:0] pendingFlags,
    output logic [NSRC-1:0] sourceMask,
    output logic [NSRC*SETTING_FIELD_W-1:0] sourceSetting,
    // External pins: host interrupt pins double as bus interrupt inputs
    input wire logic [NUM_HOST_PINS-1:0] hostIrqIn,
    output host_pins_t hostIrqPins,
    input wire logic userRequestPin
);

    // ==========================================================
    // State
    typedef struct packed {
        wb_rsp_t rsp;
        logic [NSRC-1:0] edgeFlag;
        logic [NSRC-1:0] prevLine;
        logic [NSRC-1:0] pendingView;
        logic [NSRC-1:0] mask;
        logic [NSRC*SETTING_FIELD_W-1:0] setting;
        logic [NUM_HOST_PINS-1:0] pinAssertValue;
        logic [NUM_HOST_PINS-1:0] pinDriveEnable;
        host_pins_t pins;
    } state_t;

    state_t st;
    state_t next_st;

    // ==========================================================
    // Helpers

    // Byte-lane merge used by the mask and setting registers
    function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                              input logic [31:0] wdat,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wdat[b*8 +: 8];
            end
        end
        return res;
    endfunction : laneMerge

    // Byte-lane qualified write bits for set and clear strobes
    function automatic logic [31:0] laneBits(input logic [31:0] wdat,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = '0;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wdat[b*8 +: 8];
            end
        end
        return res;
    endfunction : laneBits

    // Software-visible pending word: live line for level, flag for edge
    function automatic logic [31:0] pendingWord(input logic [31:0] levelMode,
                                                input logic [31:0] line,
                                                input logic [31:0] flag);
        return (levelMode & line) | (~levelMode & flag);
    endfunction : pendingWord

    // ==========================================================
    // Pin synchronisers
    logic [NUM_HOST_PINS:0] pinSynced;

    sync_bank #(
        .WIDTH(NUM_HOST_PINS + 1)
    ) u_pin_sync (
        .clk(clk),
        .rstn(rstn),
        .async({userRequestPin, ~hostIrqIn}),
        .synced(pinSynced)
    );  // RULE25

    // ==========================================================
    // Request lines and mode decode
    logic [NSRC-1:0] requestLine;
    logic [NSRC-1:0] levelMode;
    logic [NUM_HOST_PINS-1:0] pinLow;

    // Host pins inverted ahead of the flops, so reset shows them idle, not a false edge
    assign pinLow = pinSynced[NUM_HOST_PINS-1:0]; // RULE13 RULE18

    // Collect lines per source
    always_comb begin
        requestLine = deviceRequest & ~(RESERVED_SOURCES | SOFTWARE_SOURCES | PIN_SOURCES); // RULE15
        requestLine[SRC_PCI_FIRST +: NUM_HOST_PINS] = pinLow; // RULE12
        requestLine[SRC_USER] = pinSynced[NUM_HOST_PINS]; // RULE14
        for (int i = 0; i < NSRC; i++) begin
            levelMode[i] = st.setting[i*SETTING_FIELD_W + MODE_BIT]; // RULE21
        end
    end

    // ==========================================================
    // Bus decode
    logic busHit;
    logic wrStrobe;
    logic [31:0] wrBits;

    // One request per ack; the ack register blocks a second hit
    assign busHit = wbReq.cyc && wbReq.stb && !st.rsp.ack;
    assign wrStrobe = busHit && wbReq.we;
    assign wrBits = laneBits(wbReq.dat, wbReq.sel);

    // ==========================================================
    // Next-state logic
    logic [NSRC-1:0] edgeSet;
    logic [NSRC-1:0] edgeClear;
    logic [NSRC-1:0] dispatchBit;
    logic [NSRC-1:0] leadingEdge;
    logic [NSRC-1:0] currentView;
    logic [31:0] readWord;
    logic [31:0] hostWord;

    always_comb begin
        next_st = st;

        // Leading edge of each synchronised or on-chip line
        leadingEdge = requestLine & ~st.prevLine; // RULE22
        next_st.prevLine = requestLine;

        dispatchBit = '0;
        if (dispatchValid) begin
            dispatchBit[dispatchSource] = 1'b1;
        end

        // Set sources: hardware edge and software or remote write of 1s
        edgeSet = leadingEdge; // RULE22
        edgeClear = dispatchBit; // RULE23
        if (wrStrobe && wbReq.adr == OFF_PENDING_FLAGS) begin
            edgeSet = edgeSet | wrBits; // RULE3 RULE6 RULE7
        end
        if (wrStrobe && wbReq.adr == OFF_PENDING_CLEAR) begin
            edgeClear = edgeClear | wrBits; // RULE9
        end

        // Set beats clear; level sources hold no flag at all
        next_st.edgeFlag = (edgeSet | (st.edgeFlag & ~edgeClear)) & ~levelMode; // RULE10 RULE4

        // Flag only waits for the arbiter, nothing here traps
        currentView = pendingWord(levelMode, requestLine, st.edgeFlag); // RULE1 RULE2
        next_st.pendingView = pendingWord(levelMode, requestLine, next_st.edgeFlag); // RULE5

        // Host control word as software reads it
        hostWord = '0;
        hostWord[HOST_VALUE_LSB +: NUM_HOST_PINS] = st.pinAssertValue;
        hostWord[HOST_ENABLE_LSB +: NUM_HOST_PINS] = st.pinDriveEnable;
        hostWord[HOST_SENSE_LSB +: NUM_HOST_PINS] = pinLow; // RULE18

        // Register writes
        if (wrStrobe) begin
            case (wbReq.adr)
                OFF_SOURCE_MASK: begin
                    next_st.mask = laneMerge(st.mask, wbReq.dat, wbReq.sel);
                end
                OFF_SETTING0: begin
                    next_st.setting[0 +: 32] = laneMerge(st.setting[0 +: 32],
                                                         wbReq.dat, wbReq.sel);
                end
                OFF_SETTING1: begin
                    next_st.setting[32 +: 32] = laneMerge(st.setting[32 +: 32],
                                                          wbReq.dat, wbReq.sel);
                end
                OFF_SETTING2: begin
                    next_st.setting[64 +: 32] = laneMerge(st.setting[64 +: 32],
                                                          wbReq.dat, wbReq.sel);
                end
                OFF_SETTING3: begin
                    next_st.setting[96 +: 32] = laneMerge(st.setting[96 +: 32],
                                                          wbReq.dat, wbReq.sel);
                end
                OFF_HOST_IRQ_CONTROL: begin
                    // Sense bits are read-only and ignore the write
                    if (wbReq.sel[0]) begin
                        next_st.pinAssertValue = wbReq.dat[HOST_VALUE_LSB +: NUM_HOST_PINS];
                        next_st.pinDriveEnable = wbReq.dat[HOST_ENABLE_LSB +: NUM_HOST_PINS];
                    end // RULE16 RULE19 RULE20
                end
                default: begin
                end
            endcase
        end

        // Read mux; unmapped offsets answer zero
        case (wbReq.adr)
            OFF_PENDING_FLAGS: readWord = currentView;
            OFF_PENDING_CLEAR: readWord = currentView; // RULE8
            OFF_SOURCE_MASK: readWord = st.mask;
            OFF_SETTING0: readWord = st.setting[0 +: 32];
            OFF_SETTING1: readWord = st.setting[32 +: 32];
            OFF_SETTING2: readWord = st.setting[64 +: 32];
            OFF_SETTING3: readWord = st.setting[96 +: 32];
            OFF_HOST_IRQ_CONTROL: readWord = hostWord;
            default: readWord = RESET_WORD;
        endcase

        // Ack one cycle after the request, dropped the cycle after
        next_st.rsp.ack = busHit;
        next_st.rsp.dat = (busHit && !wbReq.we) ? readWord : RESET_WORD;

        // Open-drain pins follow software bits only, never hardware events
        next_st.pins.driveLow = '0;
        next_st.pins.oeN = ~(next_st.pinDriveEnable & next_st.pinAssertValue); // RULE17 RULE20
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st.rsp.ack <= 1'b0;
            st.rsp.dat <= RESET_WORD;
            st.edgeFlag <= RESET_WORD; // RULE24
            st.prevLine <= RESET_WORD;
            st.pendingView <= RESET_WORD;
            st.mask <= RESET_WORD; // RULE24
            st.setting <= RESET_SETTING;
            st.pinAssertValue <= RESET_HOST; // RULE26
            st.pinDriveEnable <= RESET_HOST; // RULE26
            st.pins.driveLow <= RESET_HOST;
            st.pins.oeN <= ~RESET_HOST;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs, all from the state register
    assign wbRsp = st.rsp;
    assign pendingFlags = st.pendingView;
    assign sourceMask = st.mask;
    assign sourceSetting = st.setting;
    assign hostIrqPins = st.pins;

endmodule : irq_pending_and_host_pins

// ### verification/host_pin_model.sv
// Host interrupt pin wiring: pull-up, block driver and other open-collector parties
`timescale 1ns/1ps

module host_pin_model (
    // From the block
    input wire logic [3:0] oeN,
    // Other devices sharing the pins
    input wire logic [3:0] extPullLow,
    // Resolved pin levels
    output logic [3:0] pinLevel
);
    // ==========================================================
    // Wired-AND with pull-up: a released pin floats high, never keeps its old value
    assign pinLevel = ~(~oeN | extPullLow);
endmodule : host_pin_model

// ### verification/irq_pending_and_host_pins_properties.sv
// Concurrent checks on the pending-flag and host pin block ports
`timescale 1ns/1ps

module irq_pending_and_host_pins_properties
    import irq_pkg::*;
#(
    parameter int NSRC = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Bus
    input wire wb_req_t wbReq,
    input wire wb_rsp_t wbRsp,
    // Sources and arbiter
    input wire logic [NSRC-1:0] deviceRequest,
    input wire logic dispatchValid,
    input wire logic [4:0] dispatchSource,
    input wire logic [NSRC-1:0] pendingFlags,
    input wire logic [NSRC-1:0] sourceMask,
    input wire logic [NSRC*SETTING_FIELD_W-1:0] sourceSetting,
    // Pins
    input wire logic [NUM_HOST_PINS-1:0] hostIrqIn,
    input wire host_pins_t hostIrqPins,
    input wire logic userRequestPin
);
    // ==========================================================
    // Write taken this edge; full-word variant for bit-level effects
    logic wrAny;
    logic wrFull;
    assign wrAny = wbReq.cyc && wbReq.stb && wbReq.we && !wbRsp.ack;
    assign wrFull = wrAny && (wbReq.sel == 4'hf);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ==========================================================
    // Bus handshake
    a_ack_next: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
        else $error("request not answered next cycle");
    a_ack_pulse: assert property (wbRsp.ack |=> !wbRsp.ack)
        else $error("ack stood longer than one cycle");
    a_idle_data: assert property (!wbRsp.ack |-> wbRsp.dat == 32'h0)
        else $error("read data not zero outside ack");

    // ==========================================================
    // Host pins
    a_never_high: assert property (hostIrqPins.driveLow == 4'h0)
        else $error("host pin driven to a high level");
    a_pins_by_write: assert property (!$stable(hostIrqPins.oeN) |->
        $past(wrAny) && $past(wbReq.adr) == OFF_HOST_IRQ_CONTROL)
        else $error("host pin changed without a control write");

    // ==========================================================
    // Pending flags: source 9 as level probe, 10 and 28 as edge probes
    a_level_live: assert property (sourceSetting[39] && $past(sourceSetting[39]) |->
        pendingFlags[9] == $past(deviceRequest[9]))
        else $error("level source does not follow its line");
    a_set_edge: assert property (wrFull && wbReq.adr == OFF_PENDING_FLAGS &&
        wbReq.dat[28] && !sourceSetting[115] |=> pendingFlags[28])
        else $error("software set not seen");
    a_clear_edge: assert property (wrFull && wbReq.adr == OFF_PENDING_CLEAR &&
        wbReq.dat[28] && !sourceSetting[115] |=> !pendingFlags[28])
        else $error("software clear not seen");
    a_set_wins: assert property (wrFull && wbReq.adr == OFF_PENDING_CLEAR &&
        wbReq.dat[10] && !sourceSetting[43] && $rose(deviceRequest[10]) |=> pendingFlags[10])
        else $error("clear beat a coincident hardware set");
    a_dispatch_drop: assert property (dispatchValid && dispatchSource == 5'd10 &&
        !sourceSetting[43] && !deviceRequest[10] && !wrAny |=> !pendingFlags[10])
        else $error("dispatch did not drop edge flag");
    a_reset_zero: assert property (disable iff (1'b0) !rstn |->
        pendingFlags == '0 && sourceMask == '0 && hostIrqPins.oeN == 4'hf)
        else $error("state not cleared in reset");

    // ==========================================================
    // Main scenarios reached
    c_dispatch: cover property (dispatchValid);
    c_host_drive: cover property (hostIrqPins.oeN != 4'hf);
    c_collision: cover property (wrFull && $rose(deviceRequest[10]));
endmodule : irq_pending_and_host_pins_properties

bind irq_pending_and_host_pins irq_pending_and_host_pins_properties #(.NSRC(NSRC)) chk_i (
    .clk(clk), .rstn(rstn), .wbReq(wbReq), .wbRsp(wbRsp), .deviceRequest(deviceRequest),
    .dispatchValid(dispatchValid), .dispatchSource(dispatchSource),
    .pendingFlags(pendingFlags), .sourceMask(sourceMask), .sourceSetting(sourceSetting),
    .hostIrqIn(hostIrqIn), .hostIrqPins(hostIrqPins), .userRequestPin(userRequestPin)
);

// ### verification/tb_irq_pending_and_host_pins.sv
// Self-checking bench for the pending-flag and host pin block
`timescale 1ns/1ps

module tb_irq_pending_and_host_pins
    import irq_pkg::*;
;
    typedef struct packed {
        logic [7:0] wadr;
        logic [31:0] wdat;
        logic [7:0] radr;
        logic [31:0] exp;
    } row_t;

    logic clk = 1'b0;
    logic rstn = 1'b1;
    wb_req_t wbReq = '0;
    wb_rsp_t wbRsp;
    logic [31:0] deviceRequest = '0;
    logic dispatchValid = 1'b0;
    logic [4:0] dispatchSource = 5'h00;
    logic [31:0] pendingFlags;
    logic [31:0] sourceMask;
    logic [127:0] sourceSetting;
    logic [3:0] hostIrqIn;
    host_pins_t hostIrqPins;
    logic userRequestPin = 1'b0;
    logic [3:0] extPullLow = 4'h0;
    logic [31:0] rd;
    int num_errors = 0;
    int checks_done = 0;
    // Write, then read back; later rows see the state earlier rows left
    row_t rows [8] = '{
        '{8'h08, 32'ha5a5_5a5a, 8'h08, 32'ha5a5_5a5a},
        '{8'h10, 32'h0000_0080, 8'h10, 32'h0000_0080},
        '{8'h00, 32'hf000_0000, 8'h00, 32'hf000_0000},
        '{8'h04, 32'h3000_0000, 8'h04, 32'hc000_0000},
        '{8'h1c, 32'h0000_0f00, 8'h1c, 32'h0000_0000},
        '{8'h40, 32'hffff_ffff, 8'h40, 32'h0000_0000},
        '{8'h00, 32'h0000_0200, 8'h00, 32'hc000_0000},
        '{8'h04, 32'hc000_0000, 8'h00, 32'h0000_0000}
    };

    always #10 clk = ~clk;

    irq_pending_and_host_pins irq_pending_and_host_pins_i (
        .clk(clk), .rstn(rstn), .wbReq(wbReq), .wbRsp(wbRsp), .deviceRequest(deviceRequest),
        .dispatchValid(dispatchValid), .dispatchSource(dispatchSource),
        .pendingFlags(pendingFlags), .sourceMask(sourceMask), .sourceSetting(sourceSetting),
        .hostIrqIn(hostIrqIn), .hostIrqPins(hostIrqPins), .userRequestPin(userRequestPin)
    );
    host_pin_model host_pin_model_i (
        .oeN(hostIrqPins.oeN), .extPullLow(extPullLow), .pinLevel(hostIrqIn)
    );

    // ==========================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One classic cycle; rise is ORed onto the request lines at the same edge
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           input logic [31:0] rise, output logic [31:0] rdat);
        @(posedge clk);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        deviceRequest <= deviceRequest | rise;
        // No cycle limit here: only the watchdog ends a lost answer
        do begin
            @(posedge clk);
        end while (wbRsp.ack !== 1'b1);
        rdat = wbRsp.dat;
        wbReq <= '0;
    endtask : wb_xfer

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        wb_xfer(1'b1, adr, dat, 32'h0, rd);
    endtask : wr

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        wb_xfer(1'b0, adr, 32'h0, 32'h0, rd);
        chk(rd, exp, "register read");
    endtask : rdchk

    task automatic end_sim;
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    // ==========================================================
    // Watchdog: the tests need well under 2000 cycles
    initial begin
        #100us;
        num_errors++;
        end_sim();
    end

    // ==========================================================
    // Main sequence
    initial begin
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk(pendingFlags, 32'h0, "pending after reset");
        chk(sourceMask, 32'h0, "mask after reset");
        chk({28'h0, hostIrqPins.oeN}, 32'hf, "pins after reset");
        // Let the pin synchronisers settle before trusting pending state
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            wr(rows[i].wadr, rows[i].wdat);
            rdchk(rows[i].radr, rows[i].exp);
        end
        // Handler entry: mask saved, zeroed, then restored on the way out
        rdchk(8'h08, 32'ha5a5_5a5a);
        chk(sourceMask, 32'ha5a5_5a5a, "mask out");
        wr(8'h08, 32'h0000_0000);
        chk(sourceMask, 32'h0000_0000, "mask cleared");
        wr(8'h08, 32'ha5a5_5a5a);
        rdchk(8'h08, 32'ha5a5_5a5a);
        // Level source 9 follows its line, ignores a clear write
        deviceRequest[9] <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(8'h00, 32'h0000_0200);
        wr(8'h04, 32'h0000_0200);
        rdchk(8'h04, 32'h0000_0200);
        deviceRequest[9] <= 1'b0;
        repeat (3) @(posedge clk);
        rdchk(8'h00, 32'h0000_0000);
        // Edge source 10: one-cycle pulse captured, then dispatched away
        deviceRequest[10] <= 1'b1;
        @(posedge clk);
        deviceRequest[10] <= 1'b0;
        repeat (3) @(posedge clk);
        rdchk(8'h00, 32'h0000_0400);
        chk(pendingFlags, 32'h0000_0400, "pending out");
        dispatchValid <= 1'b1;
        dispatchSource <= 5'd10;
        @(posedge clk);
        dispatchValid <= 1'b0;
        rdchk(8'h00, 32'h0000_0000);
        // Clear coinciding with a hardware edge: set wins; plain clear afterwards
        wb_xfer(1'b1, 8'h04, 32'h0000_0400, 32'h0000_0400, rd);
        rdchk(8'h00, 32'h0000_0400);
        deviceRequest[10] <= 1'b0;
        wr(8'h04, 32'h0000_0400);
        rdchk(8'h00, 32'h0000_0000);
        // Edge mode pins: user pin rises, bus pin 2 falls
        userRequestPin <= 1'b1;
        extPullLow[2] <= 1'b1;
        repeat (5) @(posedge clk);
        rdchk(8'h00, 32'h0000_0014);
        userRequestPin <= 1'b0;
        extPullLow[2] <= 1'b0;
        wr(8'h04, 32'h0000_0014);
        // Level mode pins, pin 0 driven by the block, pin 1 by another party
        wr(8'h0c, 32'h0000_8888);
        chk(sourceSetting[31:0], 32'h0000_8888, "setting out");
        wr(8'h1c, 32'h0000_0011);
        extPullLow[1] <= 1'b1;
        repeat (4) @(negedge clk);
        chk({28'h0, hostIrqPins.oeN}, 32'he, "pin drive");
        rdchk(8'h1c, 32'h0000_0311);
        rdchk(8'h00, 32'h0000_0003);
        // Value without enable leaves the pin released
        wr(8'h1c, 32'h0000_0001);
        rdchk(8'h1c, 32'h0000_0201);
        extPullLow[1] <= 1'b0;
        // Mid-run reset with state set, then no false pin edge after release
        wr(8'h1c, 32'h0000_0011);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        chk(pendingFlags, 32'h0, "pending in reset");
        chk(sourceMask, 32'h0, "mask in reset");
        chk({28'h0, hostIrqPins.oeN}, 32'hf, "pins in reset");
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        chk(pendingFlags, 32'h0, "pending after release");
        rdchk(8'h00, 32'h0000_0000);
        end_sim();
    end
endmodule : tb_irq_pending_and_host_pins
